// [src/can_transceiver_mode_control.sv]
// transceiver mode, power-down and fail-safe control
`timescale 1ns/1ps
// Functional notes
// - select low, receive-only high: normal mode
// - both selects low: receive-only mode
// - select high: power-save mode
// - mode takes effect after mode delay
// - normal: transmit, receive, bias, protections active
// - normal only above rising undervoltage threshold
// - transmit enabled only after recessive input
// - receive-only: transmitter off, no timeout
// - receive-only only above undervoltage threshold
// - power-save: receive output high, bias floats
// - filtered undervoltage forces power-down state
// - power-down: everything off, undervoltage watched
// - leave power-down after power-up delay
// - open pins read high: power-save
// - long dominant input disables transmitter
// - rising transmit edge releases timeout
// - receive output high while leaving power-save
// - overtemperature disables transmitter, hysteresis flag
// - low input dominant, dominant gives low output
// - dominant timeout between 1 and 4 ms
module can_transceiver_mode_control
  import can_mode_pkg::*;
#(
  parameter int unsigned MODE_CYCLES = can_mode_pkg::MODE_CYC,
  parameter int unsigned UV_FILTER_CYCLES = can_mode_pkg::UV_FILTER_CYC,
  parameter int unsigned PON_CYCLES = can_mode_pkg::PON_CYC,
  parameter int unsigned DOM_TIMEOUT_CYCLES = can_mode_pkg::DOM_TIMEOUT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  can_mode_if.device pins,
  input wire logic supply_above_rising,
  input wire logic supply_below_falling,
  input wire logic overtemp,
  input wire logic bus_dominant,
  output logic bus_drive_dominant,
  output logic bus_bias_on,
  output logic receiver_on,
  output logic [4:0] mode_state
);
  import can_mode_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    mode_t mode;
    mode_t target;
    logic [CNT_W-1:0] mode_cnt;
    logic [CNT_W-1:0] uv_cnt;
    logic [CNT_W-1:0] dom_cnt;
    logic tx_blocked;
    logic timed_out;
    logic ot_latched;
    logic txd_prev;
    logic rxd;
    logic drive;
    logic bias;
    logic rx_on;
  } state_t;

  state_t st;
  state_t next_st;
  mode_t req;

  // ==========================================================
  // pin decode; the pins read high when open, so idle means power-save
  always_comb begin
    if (pins.standby_select_n) begin
      req = MODE_POWER_SAVE;
    end else if (pins.receive_only_select_n) begin
      req = MODE_NORMAL;
    end else begin
      req = MODE_RX_ONLY;
    end
  end

  // ==========================================================
  // next-state logic
  always_comb begin
    next_st = st;
    next_st.txd_prev = pins.txd;
    // undervoltage filter runs in every mode, even power-down
    if (supply_below_falling) begin
      if (st.uv_cnt < CNT_W'(UV_FILTER_CYCLES)) begin
        next_st.uv_cnt = st.uv_cnt + 1'b1;
      end
    end else begin
      next_st.uv_cnt = '0;
    end
    case (st.mode)
      MODE_POWER_DOWN: begin
        // wait out the power-up delay with a good supply
        if (!supply_below_falling && st.mode_cnt < CNT_W'(PON_CYCLES)) begin
          next_st.mode_cnt = st.mode_cnt + 1'b1;
        end else if (supply_below_falling) begin
          next_st.mode_cnt = '0;
        end else begin
          next_st.mode = MODE_POWER_SAVE;
          next_st.mode_cnt = '0;
        end
      end
      MODE_CHANGING: begin
        // new mode only counts once the delay expired
        if (st.mode_cnt < CNT_W'(MODE_CYCLES)) begin
          next_st.mode_cnt = st.mode_cnt + 1'b1;
        end else begin
          next_st.mode = st.target;
          next_st.mode_cnt = '0;
          next_st.tx_blocked = 1'b1;
        end
      end
      MODE_POWER_SAVE, MODE_NORMAL, MODE_RX_ONLY: begin
        // supply gates entry into the active modes
        if (req != st.mode && (req == MODE_POWER_SAVE || supply_above_rising)) begin
          next_st.target = req;
          next_st.mode = MODE_CHANGING;
          next_st.mode_cnt = '0;
        end
      end
      default: begin
        next_st.mode = MODE_POWER_DOWN;
      end
    endcase
    // the supply check wins over any pin request
    if (st.uv_cnt >= CNT_W'(UV_FILTER_CYCLES) && supply_below_falling && st.mode != MODE_POWER_DOWN) begin
      next_st.mode = MODE_POWER_DOWN;
      next_st.mode_cnt = '0;
    end
    // recessive input after entry unblocks the path
    if (st.mode == MODE_NORMAL && st.tx_blocked && pins.txd) begin
      next_st.tx_blocked = 1'b0;
    end
    // dominant timeout counts only in normal mode
    if (st.mode == MODE_NORMAL && !pins.txd) begin
      if (st.dom_cnt < CNT_W'(DOM_TIMEOUT_CYCLES)) begin
        next_st.dom_cnt = st.dom_cnt + 1'b1;
      end else begin
        next_st.timed_out = 1'b1;
      end
    end else begin
      next_st.dom_cnt = '0;
    end
    if (st.timed_out && pins.txd && !st.txd_prev) begin
      next_st.timed_out = 1'b0;
    end
    if (st.mode != MODE_NORMAL) begin
      next_st.timed_out = 1'b0;
    end
    // sensor flag carries its own hysteresis; only watched in normal mode
    next_st.ot_latched = (st.mode == MODE_NORMAL) && overtemp;
    // outputs registered here
    next_st.drive = (next_st.mode == MODE_NORMAL) && !next_st.tx_blocked && !next_st.timed_out
                    && !next_st.ot_latched && !pins.txd;
    next_st.rx_on = (next_st.mode == MODE_NORMAL) || (next_st.mode == MODE_RX_ONLY);
    next_st.bias = next_st.rx_on;
    next_st.rxd = next_st.rx_on ? !bus_dominant : 1'b1;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{mode: MODE_POWER_DOWN, target: MODE_POWER_SAVE, mode_cnt: '0, uv_cnt: '0, dom_cnt: '0,
              tx_blocked: 1'b1, timed_out: 1'b0, ot_latched: 1'b0, txd_prev: PIN_IDLE, rxd: PIN_IDLE,
              drive: 1'b0, bias: 1'b0, rx_on: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign pins.rxd = st.rxd;
  assign bus_drive_dominant = st.drive;
  assign bus_bias_on = st.bias;
  assign receiver_on = st.rx_on;
  assign mode_state = st.mode;
endmodule

// [inc/can_mode_pkg.sv]
// shared constants and types for the transceiver mode control and its controller end
package can_mode_pkg;
  // clock rate
  localparam int unsigned CLK_HZ = 50_000_000;
  // documented times, all in microseconds
  localparam int unsigned T_MODE_US = 20;          // mode change window (typical figure)
  localparam int unsigned T_UV_FILTER_US = 10;     // undervoltage filter, longest
  localparam int unsigned T_PON_US = 280;          // power-up delay, longest
  localparam int unsigned T_DOM_TIMEOUT_US = 1000; // dominant timeout, least (1 ms)
  // cycle counts derived from the times (microseconds times whole clock MHz, no rounding step for least or longest)
  localparam int unsigned MODE_CYC = (T_MODE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned UV_FILTER_CYC = (T_UV_FILTER_US * (CLK_HZ / 1_000_000));
  localparam int unsigned PON_CYC = (T_PON_US * (CLK_HZ / 1_000_000));
  localparam int unsigned DOM_TIMEOUT_CYC = (T_DOM_TIMEOUT_US * (CLK_HZ / 1_000_000));
  localparam int unsigned CNT_W = 20;
  // reset values of the controller's own pins and registers
  localparam logic PIN_IDLE = 1'b1;
  // controller register offsets
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_TXD = 2'h2;
  // control field positions
  localparam int unsigned CTRL_STBY_BIT = 0;
  localparam int unsigned CTRL_RXONLY_BIT = 1;
  // operating modes, one-hot
  typedef enum logic [4:0] {
    MODE_POWER_DOWN = 5'b0_0001,
    MODE_POWER_SAVE = 5'b0_0010,
    MODE_NORMAL = 5'b0_0100,
    MODE_RX_ONLY = 5'b0_1000,
    MODE_CHANGING = 5'b1_0000
  } mode_t;
endpackage

// [inc/can_mode_if.sv]
// pins between the protocol controller and the transceiver
`timescale 1ns/1ps
interface can_mode_if;
  logic standby_select_n;
  logic receive_only_select_n;
  logic txd;
  logic rxd;
  modport device (input standby_select_n, input receive_only_select_n, input txd, output rxd);
  modport controller (output standby_select_n, output receive_only_select_n, output txd, input rxd);
endinterface

// [src/can_mode_controller.sv]
// controller end: register port driving the mode pins and transmit data
`timescale 1ns/1ps
module can_mode_controller
  import can_mode_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  can_mode_if.controller pins,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata
);
  import can_mode_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic stby_n;
    logic rxonly_n;
    logic txd;
    logic [7:0] rdata;
  } cstate_t;

  cstate_t st;
  cstate_t next_st;

  // register writes and one-cycle-late reads
  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    if (wr && addr == REG_CTRL) begin
      next_st.stby_n = wdata[CTRL_STBY_BIT];
      next_st.rxonly_n = wdata[CTRL_RXONLY_BIT];
    end
    if (wr && addr == REG_TXD) begin
      next_st.txd = wdata[0];
    end
    if (rd) begin
      case (addr)
        REG_CTRL: next_st.rdata = {6'h00, st.rxonly_n, st.stby_n};
        REG_STATUS: next_st.rdata = {7'h00, pins.rxd};
        REG_TXD: next_st.rdata = {7'h00, st.txd};
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // pins come up idle (high), which selects power-save
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{stby_n: PIN_IDLE, rxonly_n: PIN_IDLE, txd: PIN_IDLE, rdata: 8'h00};
    end else begin
      st <= next_st;
    end
  end

  assign pins.standby_select_n = st.stby_n;
  assign pins.receive_only_select_n = st.rxonly_n;
  assign pins.txd = st.txd;
  assign rdata = st.rdata;
endmodule

// [test/can_mode_chk.sv]
// checker on the pins between controller and transceiver
`timescale 1ns/1ps
module can_mode_chk
  import can_mode_pkg::*;
#(
  parameter int unsigned DOM_TIMEOUT_CYCLES = can_mode_pkg::DOM_TIMEOUT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic standby_select_n,
  input wire logic receive_only_select_n,
  input wire logic txd,
  input wire logic rxd,
  input wire logic bus_dominant,
  input wire logic overtemp,
  input wire logic bus_drive_dominant,
  input wire logic [4:0] mode_state
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========
  // helper: length of the present low run on the transmit pin
  int low_run;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_run <= 0;
    end else begin
      low_run <= txd ? 0 : low_run + 1;
    end
  end
  // ==========
  // properties; margin of a few cycles covers the registered outputs
  property p_psave_rxd; mode_state == MODE_POWER_SAVE |-> rxd; endproperty
  a_psave_rxd: assert property (p_psave_rxd) else $error("rxd low in power-save");
  property p_change_rxd; mode_state == MODE_CHANGING |-> rxd; endproperty
  a_change_rxd: assert property (p_change_rxd) else $error("rxd low while changing");
  property p_change_hold; $rose(mode_state == MODE_CHANGING) |-> (mode_state == MODE_CHANGING) [*8]; endproperty
  a_change_hold: assert property (p_change_hold) else $error("mode change too short");
  property p_leave; $rose(standby_select_n) && mode_state == MODE_NORMAL |-> ##[1:2] mode_state == MODE_CHANGING;
  endproperty
  a_leave: assert property (p_leave) else $error("no change on select high");
  property p_down_quiet; mode_state == MODE_POWER_DOWN && $past(mode_state) == MODE_POWER_DOWN |-> !bus_drive_dominant;
  endproperty
  a_down_quiet: assert property (p_down_quiet) else $error("drive in power-down");
  // the registered receive output follows the mode it was computed for, so the first cycle after entering normal is excluded
  property p_follow; mode_state == MODE_NORMAL && $past(mode_state) == MODE_NORMAL |->
    rxd == !$past(bus_dominant); endproperty
  a_follow: assert property (p_follow) else $error("rxd not following bus");
  property p_timeout; low_run > DOM_TIMEOUT_CYCLES + 3 |-> !bus_drive_dominant; endproperty
  a_timeout: assert property (p_timeout) else $error("drive past timeout");
  property p_hot; overtemp [*3] |-> !bus_drive_dominant; endproperty
  a_hot: assert property (p_hot) else $error("drive while hot");
  c_rxonly: cover property (mode_state == MODE_RX_ONLY && !receive_only_select_n);
  c_timeout: cover property (low_run > DOM_TIMEOUT_CYCLES + 3);
  c_hot: cover property (overtemp && mode_state == MODE_NORMAL);
endmodule

// [test/tb_top.sv]
// top bench: controller end and transceiver joined over the pins
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import can_mode_pkg::*;
  localparam int unsigned DOM = 40;
  logic clk_sys = 0, rst_n = 0, wr = 0, rd = 0, rd_d = 0;
  logic [7:0] rx_exp;
  logic supply_above_rising = 1, supply_below_falling = 0, overtemp = 0, bus_dominant = 0;
  logic bus_drive_dominant, bus_bias_on, receiver_on;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [4:0] mode_state;
  logic [7:0] exp_q[$];
  int mismatches = 0, checks_done = 0, seed = 11;
  can_mode_if pins();
  always #10 clk_sys = ~clk_sys;
  can_mode_controller can_mode_controller_i (.clk_sys(clk_sys), .rst_n(rst_n), .pins(pins), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  can_transceiver_mode_control #(.MODE_CYCLES(8), .UV_FILTER_CYCLES(4), .PON_CYCLES(16), .DOM_TIMEOUT_CYCLES(DOM))
    can_transceiver_mode_control_i (.clk_sys(clk_sys), .rst_n(rst_n), .pins(pins),
    .supply_above_rising(supply_above_rising), .supply_below_falling(supply_below_falling), .overtemp(overtemp),
    .bus_dominant(bus_dominant), .bus_drive_dominant(bus_drive_dominant), .bus_bias_on(bus_bias_on),
    .receiver_on(receiver_on), .mode_state(mode_state));
  can_mode_chk #(.DOM_TIMEOUT_CYCLES(DOM)) can_mode_chk_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .standby_select_n(pins.standby_select_n), .receive_only_select_n(pins.receive_only_select_n),
    .txd(pins.txd), .rxd(pins.rxd), .bus_dominant(bus_dominant), .overtemp(overtemp),
    .bus_drive_dominant(bus_drive_dominant), .mode_state(mode_state));
  // ==========
  // verdict
  task automatic close_out;
    if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // leading edge keeps a strobe from being set twice in one step
  task automatic put(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  // read of any register; the whole byte is compared by the monitor
  task automatic get(input logic [1:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
  endtask
  // bounded wait; running out counts as a mismatch
  task automatic wait_mode(input logic [4:0] m);
    for (int i = 0; i < 300 && mode_state !== m; i++) @(posedge clk_sys);
    `CHK(mode_state, m)
    if (mode_state !== m) close_out();
  endtask
  // ==========
  // monitor: status answer stands only the cycle after the strobe
  always @(posedge clk_sys) begin
    rd_d <= rd;
    if (rd_d) begin
      rx_exp = exp_q.pop_front();
      `CHK(rdata, rx_exp)
    end
  end
  // ==========
  // main sequence
  initial begin
    tick(20);
    rst_n <= 1'b1;
    wait_mode(MODE_POWER_SAVE);
    `CHK({bus_bias_on, receiver_on}, 2'b00)
    get(REG_STATUS, 8'h01);
    supply_above_rising <= 1'b0;
    put(REG_CTRL, 8'h02);
    get(REG_CTRL, 8'h02);
    tick(20);
    `CHK(mode_state, MODE_POWER_SAVE)
    supply_above_rising <= 1'b1;
    wait_mode(MODE_NORMAL);
    `CHK({bus_bias_on, receiver_on}, 2'b11)
    repeat (8) begin
      bus_dominant <= 1'($random(seed));
      tick(3);
      get(REG_STATUS, {7'h00, !bus_dominant});
    end
    put(REG_TXD, 8'h00);
    tick(3);
    `CHK(bus_drive_dominant, 1'b1)
    tick(DOM + 6);
    `CHK(bus_drive_dominant, 1'b0)
    put(REG_TXD, 8'h01);
    put(REG_TXD, 8'h00);
    tick(3);
    `CHK(bus_drive_dominant, 1'b1)
    overtemp <= 1'b1;
    tick(4);
    `CHK({bus_drive_dominant, mode_state}, {1'b0, MODE_NORMAL})
    overtemp <= 1'b0;
    tick(4);
    `CHK(bus_drive_dominant, 1'b1)
    put(REG_CTRL, 8'h00);
    wait_mode(MODE_RX_ONLY);
    `CHK(bus_drive_dominant, 1'b0)
    `CHK({bus_bias_on, receiver_on}, 2'b11)
    get(REG_STATUS, {7'h00, !bus_dominant});
    put(REG_CTRL, 8'h02);
    wait_mode(MODE_NORMAL);
    tick(2);
    `CHK(bus_drive_dominant, 1'b0)
    put(REG_TXD, 8'h01);
    put(REG_TXD, 8'h00);
    tick(3);
    `CHK(bus_drive_dominant, 1'b1)
    put(REG_CTRL, 8'h03);
    wait_mode(MODE_POWER_SAVE);
    supply_below_falling <= 1'b1;
    tick(3);
    supply_below_falling <= 1'b0;
    tick(2);
    `CHK(mode_state, MODE_POWER_SAVE)
    supply_below_falling <= 1'b1;
    tick(8);
    `CHK(mode_state, MODE_POWER_DOWN)
    supply_below_falling <= 1'b0;
    tick(10);
    `CHK(mode_state, MODE_POWER_DOWN)
    `CHK({bus_bias_on, receiver_on, bus_drive_dominant}, 3'b000)
    wait_mode(MODE_POWER_SAVE);
    close_out();
  end
endmodule
